// [core/sccf_map.vh]
// Constants for the serial clocking, line coding and FIFO block.
// Assumes inclusion by bare name from core/ design files.
`ifndef SCCF_MAP_VH
`define SCCF_MAP_VH
// Register offsets (byte addresses)
`define SCCF_MODE_CONFIG_REG 8'h00
`define SCCF_CLOCK_SEL_REG 8'h04
`define SCCF_TIME_CONST_REG 8'h08
`define SCCF_EXTRA_FEATURE_REG 8'h0C
`define SCCF_MAIN_STATUS_REG 8'h10
`define SCCF_SPECIAL_STATUS_REG 8'h14
`define SCCF_TX_DATA_REG 8'h18
`define SCCF_RX_DATA_REG 8'h1C
// Mode config fields
`define SCCF_CLKMODE_LSB 6
`define SCCF_ENC_LSB 0
`define SCCF_ECHO_BIT 2
`define SCCF_LOOP_BIT 3
`define SCCF_RXDMA_BIT 4
`define SCCF_ALLCHR_BIT 5
// Clock select fields
`define SCCF_TXSRC_LSB 0
`define SCCF_RXSRC_LSB 2
`define SCCF_PLLSRC_BIT 4
`define SCCF_BGSRC_BIT 5
`define SCCF_PINOUT_BIT 6
`define SCCF_PLLFM_BIT 7
// Extra feature fields
`define SCCF_TXLVL_BIT 5
`define SCCF_RXLVL_BIT 3
`define SCCF_EXTRA_RST 8'h20
// Status fields
`define SCCF_ST_RXAVAIL 0
`define SCCF_ST_TXEMPTY 2
// Encodings
`define SCCF_ENC_NRZ 2'h0
`define SCCF_ENC_NRZI 2'h1
`define SCCF_ENC_BIMARK 2'h2
`define SCCF_ENC_BISPACE 2'h3
// Clock sources
`define SCCF_SRC_PIN 2'h0
`define SCCF_SRC_BAUD 2'h1
`define SCCF_SRC_PLL 2'h2
`define SCCF_SRC_BIDIR 2'h3
// Time constant offset and receive threshold
`define SCCF_TC_OFFSET 2
`define SCCF_RX_HALF 4
`endif

// [core/sccf_core.v]
// Serial channel clocking, line coding, loop modes and data FIFOs.
// Assumes synchronous register port on ref_clk; line pins asynchronous.
// Function
// RULE1: Baud output selectable for tx, rx, loop.
// RULE2: Drive baud clock on bidir pin when free.
// RULE3: Time constant is fin over 2*baud*mode minus two.
// RULE4: Clock mode field picks 1,16,32,64.
// RULE5: Loop sampled at 32x NRZI, 16x FM.
// RULE6: Recovered tx clock is jitter-free divided input.
// RULE7: Divide 16 for FM, 32 for NRZI.
// RULE8: NRZI loop counts, nudges count on edges.
// RULE9: FM loop counts 0-31, window around 15/16.
// RULE10: Loop source selectable; output to bidir pin.
// RULE11: NRZ level coding; NRZI zero toggles.
// RULE12: Bi-phase mark: one adds mid transition.
// RULE13: Bi-phase space: zero adds mid transition.
// RULE14: Manchester decode via FM loop, NRZ receiver.
// RULE15: Auto echo sends line data straight back.
// RULE16: Local loopback ties tx to rx internally.
// RULE17: Reset flushes tx FIFO, sets tx level.
// RULE18: Level clear: request while top byte empty.
// RULE19: Level set: request only when fully empty.
// RULE20: Rx FIFO flag shows a byte present.
// RULE21: Rx DMA request whenever a byte available.
// RULE22: Rx interrupt at four bytes or one.
// RULE23: Special interrupt when marked byte in top four.
// RULE24: FIFOs keep order; full writes dropped.
`timescale 1ns/1ps
`default_nettype none
`include "sccf_map.vh"
module sccf_core #(
	parameter TX_DEPTH = 4,
	parameter RX_DEPTH = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rdata,
	// Line pins
	input wire rxd_pin,
	output reg txd_pin,
	input wire clock_input_pin,
	input wire bidir_clock_pin_in,
	output reg bidir_clock_pin_out,
	output reg bidir_clock_pin_oe,
	input wire cts_in,
	input wire carrier_detect_in,
	// Receive special condition marker from framing logic
	input wire rx_special_in,
	// Requests
	output wire tx_int,
	output wire tx_dma_req,
	output wire rx_int,
	output wire rx_dma_req,
	output wire special_int,
	// Control levels seen by framing logic
	output wire tx_enable,
	output wire rx_enable
);
	// Register state
	reg [7:0] mode_config_r; // Clock mode, coding, loop modes
	reg [7:0] clock_sel_r; // Clock sources
	reg [7:0] time_const_r; // Baud time constant
	reg [7:0] extra_feature_r; // FIFO levels
	// Synchronisers: first stage read only by second
	reg [2:0] sync1_r;
	reg [2:0] sync2_r;
	reg [1:0] sync3_r; // Handshake-level sync for cts/dcd
	reg [1:0] sync4_r;
	wire rxd_s = sync2_r[0];
	wire cin_s = sync2_r[1];
	wire bin_s = sync2_r[2];
	wire cts_s = sync4_r[0];
	wire dcd_s = sync4_r[1];
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			sync3_r <= 2'h0;
			sync4_r <= 2'h0;
		end else begin
			sync1_r <= {bidir_clock_pin_in, clock_input_pin, rxd_pin};
			sync2_r <= sync1_r;
			sync3_r <= {carrier_detect_in, cts_in};
			sync4_r <= sync3_r;
		end
	end

	// Field decodes
	wire [1:0] enc = mode_config_r[`SCCF_ENC_LSB+1:`SCCF_ENC_LSB];
	wire echo_on = mode_config_r[`SCCF_ECHO_BIT];
	wire loop_on = mode_config_r[`SCCF_LOOP_BIT];
	wire [1:0] tx_src = clock_sel_r[`SCCF_TXSRC_LSB+1:`SCCF_TXSRC_LSB];
	wire [1:0] rx_src = clock_sel_r[`SCCF_RXSRC_LSB+1:`SCCF_RXSRC_LSB];
	wire tx_lvl = extra_feature_r[`SCCF_TXLVL_BIT];
	wire rx_lvl = extra_feature_r[`SCCF_RXLVL_BIT];

	// Clock mode divide factor 1/16/32/64
	function [6:0] sccf_div;
		input [1:0] m;
		begin
			case (m)
				2'h0: sccf_div = 7'h01;
				2'h1: sccf_div = 7'h10;
				2'h2: sccf_div = 7'h20;
				default: sccf_div = 7'h40;
			endcase
		end
	endfunction
	wire [6:0] clk_div = sccf_div(mode_config_r[`SCCF_CLKMODE_LSB+1:`SCCF_CLKMODE_LSB]); // [RULE4]

	// Baud generator input edges: pin clock or ref clock
	reg cin_d_r;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			cin_d_r <= 1'b0;
		else
			cin_d_r <= cin_s;
	end
	wire bg_tick = clock_sel_r[`SCCF_BGSRC_BIT] ? (cin_s & ~cin_d_r) : 1'b1;

	// Baud generator: reload TC+2 half periods realises the formula
	reg [8:0] bg_cnt_r;
	reg baud_r; // Square wave output, starts high
	reg baud_d_r;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bg_cnt_r <= 9'h000;
			baud_r <= 1'b1;
			baud_d_r <= 1'b1;
		end else begin
			baud_d_r <= baud_r;
			if (bg_tick) begin
				if (bg_cnt_r == 9'h000) begin
					// Half period is time constant plus two input clocks
					bg_cnt_r <= {1'b0, time_const_r} + 9'd`SCCF_TC_OFFSET - 9'h001; // [RULE3]
					baud_r <= ~baud_r;
				end else
					bg_cnt_r <= bg_cnt_r - 9'h001;
			end
		end
	end
	wire baud_tick = baud_r & ~baud_d_r;

	// Loop sampling clock: pin or baud output
	wire pll_tick = clock_sel_r[`SCCF_PLLSRC_BIT] ? baud_tick : (cin_s & ~cin_d_r); // [RULE10] [RULE1]

	// Recovered-clock loop; FM counting may be forced for Manchester with an NRZ receiver
	wire fm_mode = enc[1];
	wire pll_fm = fm_mode || clock_sel_r[`SCCF_PLLFM_BIT]; // [RULE14]
	reg [4:0] pll_cnt_r;
	reg rx_line_d_r;
	reg adj_r; // Pending adjustment, applied next cycle
	reg adj_dir_r; // 1 = late, skip ahead
	reg [4:0] free_cnt_r; // Free-running divider for jitter-free tx clock
	reg txd_int; // Coded internal transmit data
	wire line_in = loop_on ? txd_int : rxd_s;
	wire edge_seen = line_in ^ rx_line_d_r;
	// FM window: counts 12..19 centred on 15/16
	wire fm_win = (pll_cnt_r >= 5'h0C) && (pll_cnt_r <= 5'h13); // [RULE9]
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pll_cnt_r <= 5'h00;
			rx_line_d_r <= 1'b0;
			adj_r <= 1'b0;
			adj_dir_r <= 1'b0;
			free_cnt_r <= 5'h00;
		end else if (pll_tick) begin // [RULE5]
			rx_line_d_r <= line_in;
			free_cnt_r <= free_cnt_r + 5'h01;
			if (adj_r) begin
				// Nudge one count toward cell centre
				pll_cnt_r <= adj_dir_r ? pll_cnt_r + 5'h02 : pll_cnt_r; // [RULE8]
				adj_r <= 1'b0;
			end else
				pll_cnt_r <= pll_cnt_r + 5'h01;
			if (edge_seen && (!pll_fm || fm_win)) begin
				adj_r <= 1'b1; // [RULE8] [RULE9]
				// Edge expected at 15/16 in both codings
				adj_dir_r <= (pll_cnt_r < 5'h10);
			end
		end
	end
	// NRZI bit clock each 32 counts, FM each 16 (two bits per 32)
	wire rec_clk = pll_fm ? pll_cnt_r[3] : pll_cnt_r[4]; // [RULE9]
	wire jf_clk = pll_fm ? free_cnt_r[3] : free_cnt_r[4]; // [RULE6] [RULE7]

	// Clock selection
	function sccf_pick;
		input [1:0] s;
		input pin;
		input baud;
		input pll;
		input bid;
		begin
			case (s)
				`SCCF_SRC_PIN: sccf_pick = pin;
				`SCCF_SRC_BAUD: sccf_pick = baud;
				`SCCF_SRC_PLL: sccf_pick = pll;
				default: sccf_pick = bid;
			endcase
		end
	endfunction
	wire tx_clk = sccf_pick(tx_src, cin_s, baud_r, jf_clk, bin_s); // [RULE1] [RULE6]
	wire rx_clk = sccf_pick(rx_src, cin_s, baud_r, rec_clk, bin_s); // [RULE1]
	reg tx_clk_d_r;
	reg rx_clk_d_r;
	reg [5:0] txm_cnt_r; // Clock mode divider, transmit
	reg [5:0] rxm_cnt_r; // Clock mode divider, receive
	// Transmit launches on the rising edge, receive samples half a clock later
	wire tx_edge = tx_clk & ~tx_clk_d_r;
	wire rx_rise = rx_clk & ~rx_clk_d_r;
	wire rx_edge = ~rx_clk & rx_clk_d_r;
	// Only every Nth edge makes a bit; 64 wraps to zero in six bits and still works
	wire tx_bit_tick = tx_edge && (txm_cnt_r == clk_div[5:0] - 6'h01); // [RULE4]
	wire rx_bit_tick = rx_edge && (rxm_cnt_r == clk_div[5:0] - 6'h01); // [RULE4]
	// Edge history and clock mode counters
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_clk_d_r <= 1'b0;
			rx_clk_d_r <= 1'b0;
			txm_cnt_r <= 6'h00;
			rxm_cnt_r <= 6'h00;
		end else begin
			tx_clk_d_r <= tx_clk;
			rx_clk_d_r <= rx_clk;
			if (tx_edge)
				txm_cnt_r <= tx_bit_tick ? 6'h00 : txm_cnt_r + 6'h01;
			if (rx_edge)
				rxm_cnt_r <= rx_bit_tick ? 6'h00 : rxm_cnt_r + 6'h01;
		end
	end
	wire pin_is_input = (tx_src == `SCCF_SRC_BIDIR) || (rx_src == `SCCF_SRC_BIDIR);

	// Transmit FIFO
	reg [7:0] tx_mem [0:TX_DEPTH-1];
	reg [2:0] tx_cnt_r;
	reg [1:0] tx_rd_r;
	reg [1:0] tx_wr_r;
	wire tx_push = wr_stb && (addr == `SCCF_TX_DATA_REG) && (tx_cnt_r != TX_DEPTH); // [RULE24]
	reg [7:0] tx_sh_r; // Transmit shift register
	reg [3:0] tx_bits_r;
	reg tx_half_r; // Second half of bi-phase cell
	reg tx_cur_r; // Current bit
	wire tx_go = tx_bit_tick && (echo_on || loop_on || cts_s);
	wire tx_load = tx_go && !tx_half_r && (tx_bits_r == 4'h0) && (tx_cnt_r != 3'h0);
	wire tx_pop = tx_load;
	integer i;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < TX_DEPTH; i = i + 1)
				tx_mem[i] <= 8'h00;
			tx_cnt_r <= 3'h0; // [RULE17]
			tx_rd_r <= 2'h0;
			tx_wr_r <= 2'h0;
			tx_sh_r <= 8'hFF;
			tx_bits_r <= 4'h0;
			tx_half_r <= 1'b0;
			tx_cur_r <= 1'b1;
			txd_int <= 1'b1;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wr_r] <= wdata;
				tx_wr_r <= tx_wr_r + 2'h1;
			end
			if (tx_pop)
				tx_rd_r <= tx_rd_r + 2'h1;
			tx_cnt_r <= tx_cnt_r + {2'h0, tx_push} - {2'h0, tx_pop}; // [RULE24]
			if (tx_go) begin
				if (fm_mode && !tx_half_r) begin
					// Mid-cell: mark toggles on one, space on zero
					if (tx_cur_r == (enc == `SCCF_ENC_BIMARK))
						txd_int <= ~txd_int; // [RULE12] [RULE13]
					tx_half_r <= 1'b1;
				end else begin
					tx_half_r <= 1'b0;
					// Idle sends ones when nothing queued
					if (tx_load) begin
						tx_cur_r <= tx_mem[tx_rd_r][0];
						tx_sh_r <= {1'b1, tx_mem[tx_rd_r][7:1]};
						tx_bits_r <= 4'h7;
					end else begin
						tx_cur_r <= tx_sh_r[0];
						tx_sh_r <= {1'b1, tx_sh_r[7:1]};
						tx_bits_r <= (tx_bits_r == 4'h0) ? 4'h0 : tx_bits_r - 4'h1;
					end
					case (enc)
						`SCCF_ENC_NRZ: txd_int <= tx_load ? tx_mem[tx_rd_r][0] : tx_sh_r[0]; // [RULE11]
						`SCCF_ENC_NRZI: begin
							if (!(tx_load ? tx_mem[tx_rd_r][0] : tx_sh_r[0]))
								txd_int <= ~txd_int; // [RULE11]
						end
						default: txd_int <= ~txd_int; // [RULE12] [RULE13]
					endcase
				end
			end
		end
	end

	// Transmit pin: echo passes line data undecoded
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			txd_pin <= 1'b1;
		else
			txd_pin <= (echo_on || loop_on) ? rxd_s : txd_int; // [RULE15] [RULE16]
	end

	// Receive decode; NRZI/FM decode from level changes
	reg rx_prev_r;
	reg rx_mid_r;
	reg [7:0] rx_sh_r;
	reg [3:0] rx_bits_r;
	wire rx_go = rx_bit_tick && (loop_on || dcd_s);
	wire rx_bit = (enc == `SCCF_ENC_NRZI) ? (line_in == rx_prev_r) :
		(fm_mode ? ((line_in != rx_mid_r) == (enc == `SCCF_ENC_BIMARK)) : line_in); // [RULE11] [RULE14]
	wire rx_done = rx_go && (rx_bits_r == 4'h7);
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_prev_r <= 1'b0;
			rx_mid_r <= 1'b0;
			rx_sh_r <= 8'h00; // [RULE20]
			rx_bits_r <= 4'h0;
		end else begin
			// Mid-cell level, taken between two bit samples
			if (rx_rise)
				rx_mid_r <= line_in;
			if (rx_go) begin
				rx_prev_r <= line_in;
				rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
				rx_bits_r <= rx_done ? 4'h0 : rx_bits_r + 4'h1;
			end
		end
	end

	// Receive FIFO with special marker per byte
	reg [8:0] rx_mem [0:RX_DEPTH-1];
	reg [3:0] rx_cnt_r;
	reg [2:0] rx_rd_r;
	reg [2:0] rx_wr_r;
	reg rx_ovr_r; // Sticky overrun
	integer k; // Reset loop index, receive side
	wire rx_pop = rd_stb && (addr == `SCCF_RX_DATA_REG) && (rx_cnt_r != 4'h0);
	wire rx_push = rx_done && (rx_cnt_r != RX_DEPTH);
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (k = 0; k < RX_DEPTH; k = k + 1)
				rx_mem[k] <= 9'h000;
			rx_cnt_r <= 4'h0; // [RULE20]
			rx_rd_r <= 3'h0;
			rx_wr_r <= 3'h0;
			rx_ovr_r <= 1'b0;
		end else begin
			if (rx_push) begin
				rx_mem[rx_wr_r] <= {rx_special_in, rx_bit, rx_sh_r[7:1]};
				rx_wr_r <= rx_wr_r + 3'h1;
			end
			if (rx_pop)
				rx_rd_r <= rx_rd_r + 3'h1;
			rx_cnt_r <= rx_cnt_r + {3'h0, rx_push} - {3'h0, rx_pop}; // [RULE24]
			// Set wins over read clear
			if (rx_done && !rx_push)
				rx_ovr_r <= 1'b1;
			else if (rd_stb && addr == `SCCF_SPECIAL_STATUS_REG)
				rx_ovr_r <= 1'b0;
		end
	end

	// Special marker in any of top four positions; empty slots never count
	wire [3:0] spec_hit;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_top4
			localparam [2:0] OFS = g;
			assign spec_hit[g] = (rx_cnt_r > OFS) && rx_mem[rx_rd_r + OFS][8]; // [RULE23]
		end
	endgenerate
	wire spec_top4 = |spec_hit;

	// Requests
	wire tx_top_empty = (tx_cnt_r != TX_DEPTH);
	wire tx_all_empty = (tx_cnt_r == 3'h0);
	assign tx_int = tx_lvl ? tx_all_empty : tx_top_empty; // [RULE18] [RULE19]
	// Drop for the write cycle so each write shows as a new request
	assign tx_dma_req = (tx_lvl ? tx_all_empty : tx_top_empty) && !tx_push && !echo_on; // [RULE18] [RULE19] [RULE15]
	assign rx_dma_req = mode_config_r[`SCCF_RXDMA_BIT] && (rx_cnt_r != 4'h0) && !rx_pop; // [RULE21]
	assign rx_int = rx_lvl ? (rx_cnt_r >= `SCCF_RX_HALF) : (rx_cnt_r != 4'h0); // [RULE22]
	assign special_int = rx_lvl && mode_config_r[`SCCF_ALLCHR_BIT] && spec_top4; // [RULE23]
	assign tx_enable = echo_on || loop_on || cts_s; // [RULE15] [RULE16]
	assign rx_enable = loop_on || dcd_s; // [RULE16]

	// Bidir clock pin drive when no direction uses it as input
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bidir_clock_pin_out <= 1'b0;
			bidir_clock_pin_oe <= 1'b0;
		end else begin
			bidir_clock_pin_oe <= clock_sel_r[`SCCF_PINOUT_BIT] && !pin_is_input; // [RULE2] [RULE10]
			bidir_clock_pin_out <= (rx_src == `SCCF_SRC_PLL) ? rec_clk : baud_r;
		end
	end

	// Register writes
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode_config_r <= 8'h00;
			clock_sel_r <= 8'h00;
			time_const_r <= 8'h00;
			extra_feature_r <= `SCCF_EXTRA_RST; // [RULE17]
		end else if (wr_stb) begin
			if (addr == `SCCF_MODE_CONFIG_REG)
				mode_config_r <= wdata;
			else if (addr == `SCCF_CLOCK_SEL_REG)
				clock_sel_r <= wdata;
			else if (addr == `SCCF_TIME_CONST_REG)
				time_const_r <= wdata;
			else if (addr == `SCCF_EXTRA_FEATURE_REG)
				extra_feature_r <= {1'b0, wdata[6:0]};
		end
	end

	// Read data one cycle after strobe; unmapped read zero
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rdata <= 8'h00;
		else if (rd_stb) begin
			if (addr == `SCCF_MODE_CONFIG_REG)
				rdata <= mode_config_r;
			else if (addr == `SCCF_CLOCK_SEL_REG)
				rdata <= clock_sel_r;
			else if (addr == `SCCF_TIME_CONST_REG)
				rdata <= time_const_r;
			else if (addr == `SCCF_EXTRA_FEATURE_REG)
				rdata <= extra_feature_r;
			else if (addr == `SCCF_MAIN_STATUS_REG)
				rdata <= {4'h0, 1'b0, tx_top_empty, 1'b0, rx_cnt_r != 4'h0}; // [RULE18] [RULE20]
			else if (addr == `SCCF_SPECIAL_STATUS_REG)
				rdata <= {2'h0, rx_ovr_r, 4'h0, spec_top4};
			else if (addr == `SCCF_RX_DATA_REG)
				rdata <= (rx_cnt_r != 4'h0) ? rx_mem[rx_rd_r][7:0] : 8'h00;
			else
				rdata <= 8'h00;
		end
	end
endmodule // sccf_core
`default_nettype wire

// [sim/sccf_props.sv]
// Checker for the clocking, coding and FIFO block.
// Assumes bind onto sccf_core; shadows config writes.
`timescale 1ns/1ps
`default_nettype none
module sccf_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	// Pins and requests
	input wire logic rxd_pin,
	input wire logic txd_pin,
	input wire logic bidir_clock_pin_out,
	input wire logic bidir_clock_pin_oe,
	input wire logic tx_int,
	input wire logic tx_dma_req,
	input wire logic rx_dma_req,
	input wire logic tx_enable,
	input wire logic rx_enable
);
	logic [7:0] mode_r; // Shadow mode config
	logic [7:0] csel_r; // Shadow clock select
	logic [7:0] tc_r; // Shadow time constant
	logic [7:0] extra_r; // Shadow extra features
	logic pin_ok; // Bidir pin free and drive asked
	// Latch config on the same edge as the block
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode_r <= 8'h00;
			csel_r <= 8'h00;
			tc_r <= 8'h00;
			extra_r <= 8'h20;
		end else if (wr_stb) begin
			case (addr)
				8'h00: mode_r <= wdata;
				8'h04: csel_r <= wdata;
				8'h08: tc_r <= wdata;
				8'h0C: extra_r <= {1'b0, wdata[6:0]};
				default: ;
			endcase
		end
	end
	// Pin may carry a clock only when no source uses it
	assign pin_ok = csel_r[6] && (csel_r[1:0] != 2'h3) && (csel_r[3:2] != 2'h3);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_RESET_TX: assert property ($rose(nrst) |-> tx_int && tx_dma_req)
		else $error("tx request low after reset");
	AST_PIN_ON: assert property (pin_ok [*3] |-> bidir_clock_pin_oe)
		else $error("bidir pin not driven");
	AST_PIN_OFF: assert property (!pin_ok [*3] |-> !bidir_clock_pin_oe)
		else $error("bidir pin driven while in use");
	// Time constant zero gives a half period of two ticks
	AST_BAUD_HALF: assert property (bidir_clock_pin_oe && csel_r == 8'h45 && tc_r == 8'h00
		&& $changed(bidir_clock_pin_out) |=> $stable(bidir_clock_pin_out) ##1 $changed(bidir_clock_pin_out))
		else $error("baud half period wrong");
	AST_ECHO: assert property ((mode_r[2] && $stable(rxd_pin)) [*6] |-> txd_pin == rxd_pin)
		else $error("echo line mismatch");
	AST_ECHO_EN: assert property (mode_r[2] |-> tx_enable)
		else $error("echo did not bypass clear to send");
	AST_LOOP_EN: assert property (mode_r[3] |-> tx_enable && rx_enable)
		else $error("loopback enables low");
	AST_RXDMA: assert property (rx_dma_req |-> mode_r[4])
		else $error("rx request while disabled");
	AST_TXLVL: assert property (extra_r[5] && wr_stb && addr == 8'h18 |=> !tx_int [*2])
		else $error("tx interrupt with bytes queued");
endmodule // sccf_props
bind sccf_core sccf_props sccf_props_inst (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rxd_pin, .txd_pin,
	.bidir_clock_pin_out, .bidir_clock_pin_oe, .tx_int, .tx_dma_req, .rx_dma_req, .tx_enable, .rx_enable);
`default_nettype wire

// [sim/sccf_line_peer.sv]
// Remote station on the line: raw received data, still clock.
// Assumes the bench clock; levels hold eight cycles each.
`timescale 1ns/1ps
`default_nettype none
module sccf_line_peer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Traffic on or off
	input wire logic wiggle,
	// Line toward the block
	output logic rxd_pin,
	output logic clock_input_pin
);
	integer seed = 32'hCB63; // Fixed seed, repeatable line
	logic [2:0] hold_r; // Position within a level
	// Raw levels, never coded, so echo must copy them
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rxd_pin <= 1'b1;
			hold_r <= 3'h0;
		end else if (!wiggle) begin
			rxd_pin <= 1'b1; // Mark idle
		end else begin
			hold_r <= hold_r + 3'h1;
			if (hold_r == 3'h0) rxd_pin <= 1'($random(seed));
		end
	end
	// No frames clocked from here, so the clock stands still
	assign clock_input_pin = 1'b0;
endmodule // sccf_line_peer
`default_nettype wire

// [sim/serial_clock_coding_fifos_test.sv]
// Bench for the clocking, coding and FIFO block.
// Assumes core/ on the include path; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module serial_clock_coding_fifos_test;
	// Register port
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rdata;
	// Line side; enables held off to keep tx idle
	logic rxd_pin, txd_pin, clock_input_pin, bidir_clock_pin_out, bidir_clock_pin_oe, bidir_wire;
	logic cts_in = 1'b0;
	logic carrier_detect_in = 1'b0;
	logic rx_special_in = 1'b1;
	logic wiggle = 1'b0;
	// Requests
	logic tx_int, tx_dma_req, rx_int, rx_dma_req, special_int, tx_enable, rx_enable;
	// Scoreboard
	integer failures = 0;
	integer n_tests = 0;
	integer seed = 32'hCB63;
	integer i;
	integer still = 0; // Cycles the line level has held
	logic rxd_d;
	logic rd_pend = 1'b0;
	logic [7:0] exp_q[$]; // Read data owed
	logic [7:0] tx_q[$]; // Bytes kept by the FIFO
	always #50 ref_clk = ~ref_clk;
	// Pin sits low when nobody drives it
	assign bidir_wire = bidir_clock_pin_oe ? bidir_clock_pin_out : 1'b0;
	sccf_core sccf_core_inst (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rxd_pin, .txd_pin,
		.clock_input_pin, .bidir_clock_pin_in(bidir_wire), .bidir_clock_pin_out, .bidir_clock_pin_oe, .cts_in,
		.carrier_detect_in, .rx_special_in, .tx_int, .tx_dma_req, .rx_int, .rx_dma_req, .special_int, .tx_enable,
		.rx_enable);
	sccf_line_peer sccf_line_peer_inst (.ref_clk, .nrst, .wiggle, .rxd_pin, .clock_input_pin);
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One strobe cycle; reads leave their expectation queued
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= wr;
		rd_stb <= !wr;
		if (!wr) exp_q.push_back(d);
	endtask
	// Quiet cycles, then step past the edge
	task automatic idle(input integer n);
		repeat (n) begin
			@(posedge ref_clk);
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
		end
		#10;
	endtask
	task automatic put_tx(input logic keep);
		logic [7:0] b;
		b = 8'($random(seed));
		if (keep) tx_q.push_back(b);
		bus(1'b1, 8'h18, b);
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Read data stands one cycle after the strobe
	always @(negedge ref_clk) begin
		if (rd_pend) check("rdata", rdata, exp_q.pop_front());
		rd_pend = rd_stb;
	end
	// Count how long the received level has held
	always @(posedge ref_clk) begin
		rxd_d <= rxd_pin;
		still <= (rxd_pin === rxd_d) ? still + 1 : 0;
	end
	// Hang guard, far beyond the run's few hundred cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		idle(2);
		check("tx_int", {7'h00, tx_int}, 8'h01);
		check("rx_dma_req", {7'h00, rx_dma_req}, 8'h00);
		bus(1'b1, 8'h40, 8'hFF); // Unmapped, must be ignored
		bus(1'b0, 8'h0C, 8'h20);
		bus(1'b0, 8'h10, 8'h04);
		bus(1'b0, 8'h1C, 8'h00);
		bus(1'b0, 8'h40, 8'h00);
		// Level set: one queued byte silences the request
		put_tx(1'b1);
		idle(1);
		check("tx_int", {7'h00, tx_int}, 8'h00);
		bus(1'b0, 8'h10, 8'h04);
		// Level clear: request stands until full
		bus(1'b1, 8'h0C, 8'h08);
		put_tx(1'b1);
		put_tx(1'b1);
		idle(1);
		check("tx_dma_req", {7'h00, tx_dma_req}, 8'h01);
		put_tx(1'b1);
		idle(1);
		check("tx_int", {7'h00, tx_int}, 8'h00);
		bus(1'b0, 8'h10, 8'h00);
		put_tx(1'b0);
		// Loopback at x1 from the baud generator
		bus(1'b1, 8'h08, 8'h00);
		bus(1'b1, 8'h04, 8'h4D);
		idle(3);
		check("oe", {7'h00, bidir_clock_pin_oe}, 8'h00);
		bus(1'b1, 8'h04, 8'h45);
		bus(1'b1, 8'h00, 8'h38);
		idle(3);
		check("oe", {7'h00, bidir_clock_pin_oe}, 8'h01);
		check("rx_enable", {7'h00, rx_enable}, 8'h01);
		for (i = 0; i < 20000 && rx_int !== 1'b1; i++) idle(1);
		check("rx_int", {7'h00, rx_int}, 8'h01);
		check("rx_dma_req", {7'h00, rx_dma_req}, 8'h01);
		check("special_int", {7'h00, special_int}, 8'h01);
		bus(1'b0, 8'h14, 8'h01);
		for (i = 0; i < 4; i++) bus(1'b0, 8'h1C, tx_q.pop_front());
		bus(1'b0, 8'h10, 8'h04);
		idle(2);
		check("rx_dma_req", {7'h00, rx_dma_req}, 8'h00);
		check("special_int", {7'h00, special_int}, 8'h00);
		// Echo in NRZI: line data must come back undecoded
		bus(1'b1, 8'h00, 8'h05);
		wiggle <= 1'b1;
		idle(2);
		check("tx_enable", {7'h00, tx_enable}, 8'h01);
		for (i = 0; i < 160; i++) begin
			idle(1);
			// Level before this edge; the pin may just have moved on
			if (still > 4) check("txd_pin", {7'h00, txd_pin}, {7'h00, rxd_d});
		end
		tally_and_finish;
	end
endmodule // serial_clock_coding_fifos_test
`default_nettype wire
